// *** bench/dss_motor_model.sv ***
// behavioural motor behind the output stage, answers the speed search
`timescale 1ns/1ps
`default_nettype none
module dss_motor_model import dss_pkg::*; (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [FW-1:0] freq_i,
  input wire logic [FW-1:0] speed_i,
  input wire logic rev_i,
  output logic match_o,
  output logic rev_o
);
  logic [FW-1:0] prev_q = 16'h0000;
  logic en_q = 1'b0;
  logic match_q = 1'b0;
  logic rev_q = 1'b0;
  // match only when a driven sweep crosses the rotor speed
  always @(posedge clk_i) begin
    prev_q <= freq_i;
    en_q <= en_i;
    match_q <= en_i && en_q && ((prev_q >= speed_i && freq_i <= speed_i) ||
      (prev_q <= speed_i && freq_i >= speed_i));
    // direction sense is meaningless with the stage off
    rev_q <= en_i ? rev_i : ~rev_q;
  end
  assign match_o = match_q;
  assign rev_o = rev_q;
endmodule : dss_motor_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the drive start/stop sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dss_pkg::*;
  localparam int TK = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = 4'h0;
  logic [DW-1:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic run = 1'b0;
  logic dir = 1'b0;
  logic rev_set = 1'b0;
  logic [FW-1:0] mspeed = 16'h0000;
  logic match;
  logic mrev;
  logic [DW-1:0] rdata;
  logic [FW-1:0] freq;
  logic oen;
  logic brk;
  logic pex;
  logic rev;
  logic [PCTW-1:0] cur;
  logic brake_seen = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [DW-1:0] cfg_v [14] = '{16'h0000, 16'h00c8, 16'h0003, 16'h001e, 16'h0000,
    16'h0064, 16'h01f4, 16'h0002, 16'h0028, 16'h0003, 16'h03e8, 16'h0064,
    16'h0064, 16'h1388};

  always #10 clk = ~clk;

  dss_sequencer #(.TICK_CYCLES(TK)) uut (
    .CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RUN_CMD_I(run), .DIR_REV_I(dir), .SPEED_MATCH_I(match),
    .MOTOR_REV_I(mrev), .RDATA_O(rdata), .FREQ_O(freq), .OUTPUT_EN_O(oen),
    .DC_BRAKE_O(brk), .PREEXCITE_O(pex), .BRAKE_CURRENT_O(cur), .REVERSE_O(rev));

  dss_motor_model motor (
    .clk_i(clk), .en_i(oen), .freq_i(freq), .speed_i(mspeed), .rev_i(rev_set),
    .match_o(match), .rev_o(mrev));

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // run ceiling well above the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (brk === 1'b1) brake_seen = 1'b1;
    if (cyc >= 40000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask : chk1

  task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic go(input logic v);
    @(posedge clk) run <= v;
  endtask : go

  task automatic wait_st(input logic [3:0] s, input int lim);
    logic [DW-1:0] v;
    int i;
    i = 0;
    v = 16'h0000;
    do begin
      reg_rd(REG_STATUS, v);
      i++;
    end while (v[3:0] !== s && i < lim);
    chk({12'h000, v[3:0]}, {12'h000, s});
  endtask : wait_st

  task automatic wait_f(input logic [FW-1:0] f, input int lim);
    int i;
    for (i = 0; i < lim && freq !== f; i++) @(posedge clk) #1;
    chk(freq, f);
  endtask : wait_f

  task automatic t_regs;
    logic [DW-1:0] v;
    reg_rd(REG_MAX_FREQ, v);
    chk(v, MAX_FREQ_RST);
    reg_wr(REG_START_FREQ, 16'h07d0);
    reg_rd(REG_START_FREQ, v);
    chk(v, STARTUP_FREQ_MAX);
    reg_wr(REG_STATUS, 16'h00ff);
    reg_rd(REG_STATUS, v);
    chk(v, 16'h0000);
  endtask : t_regs

  task automatic t_standby;
    logic [DW-1:0] v;
    reg_wr(REG_TARGET_FREQ, 16'h0064);
    go(1'b1);
    repeat (20) @(posedge clk);
    reg_rd(REG_STATUS, v);
    chk({11'h000, v[4:0]}, 16'h0000);
    go(1'b0);
    repeat (4) @(posedge clk);
    reg_wr(REG_TARGET_FREQ, 16'h03e8);
  endtask : t_standby

  task automatic t_direct;
    logic [DW-1:0] v;
    reg_wr(REG_CTRL, 16'h0000);
    go(1'b1);
    repeat (4) @(posedge clk);
    #1 chk1(oen, 1'b1);
    chk(freq, 16'h00c8);
    chk1(brk, 1'b0);
    repeat (14) @(posedge clk);
    #1 chk(freq, 16'h00c8);
    reg_rd(REG_FREQ, v);
    chk(v, 16'h00c8);
    wait_st(ST_RUN, 20);
    wait_f(16'h03e8, 300);
    go(1'b0);
    wait_st(ST_DECEL, 5);
    wait_st(ST_SWAIT, 100);
    chk1(oen, 1'b0);
    chk(freq, 16'h0000);
    wait_st(ST_STBRK, 30);
    chk1(brk, 1'b1);
    chk(16'(cur), 16'h0028);
    wait_st(ST_IDLE, 40);
    chk1(brk, 1'b0);
  endtask : t_direct

  task automatic t_sbrk;
    reg_wr(REG_START_TIME, 16'h0002);
    reg_wr(REG_CTRL, 16'h0004);
    go(1'b1);
    wait_st(ST_SBRK, 5);
    chk1(brk, 1'b1);
    chk(16'(cur), 16'h001e);
    wait_st(ST_HOLD, 20);
    chk(freq, 16'h00c8);
    chk1(brk, 1'b0);
    go(1'b0);
    repeat (4) @(posedge clk);
    #1 chk1(oen, 1'b0);
    wait_st(ST_IDLE, 10);
  endtask : t_sbrk

  task automatic t_preex;
    logic [DW-1:0] ctl [3] = '{16'h0025, 16'h0005, 16'h0025};
    logic [DW-1:0] tm [3] = '{16'h0002, 16'h0002, 16'h0000};
    for (int k = 0; k < 3; k++) begin
      reg_wr(REG_CTRL, ctl[k]);
      reg_wr(REG_START_TIME, tm[k]);
      go(1'b1);
      repeat (4) @(posedge clk);
      #1 chk1(pex, k == 0);
      chk1(oen, k != 0);
      chk1(brk, 1'b0);
      if (k == 0) begin
        chk(16'(cur), 16'h001e);
        wait_st(ST_HOLD, 20);
      end
      go(1'b0);
      wait_st(ST_IDLE, 10);
    end
  endtask : t_preex

  task automatic t_track;
    logic [1:0] code [3] = '{SEARCH_MAX, SEARCH_ZERO, SEARCH_LAST};
    logic [FW-1:0] sp [3] = '{16'h0bb8, 16'h07d0, 16'h05dc};
    for (int k = 0; k < 3; k++) begin
      reg_wr(REG_CTRL, {11'h000, code[k], 3'h6});
      mspeed <= sp[k];
      rev_set <= ~k[0];
      go(1'b1);
      wait_st(ST_SEARCH, 5);
      wait_st(ST_RUN, 800);
      chk1(freq > sp[k] - 16'h012c && freq < sp[k] + 16'h012c, 1'b1);
      chk1(rev, rev_set);
      go(1'b0);
      wait_st(ST_IDLE, 10);
    end
  endtask : t_track

  // same search from zero at two rates: the slower rate must take longer
  task automatic t_rate;
    logic [DW-1:0] v;
    int n [2];
    for (int k = 0; k < 2; k++) begin
      reg_wr(REG_SEARCH_RATE, (k == 0) ? 16'h0064 : 16'h0032);
      reg_wr(REG_CTRL, 16'h000e);
      mspeed <= 16'h07d0;
      go(1'b1);
      wait_st(ST_SEARCH, 5);
      n[k] = 0;
      do begin
        reg_rd(REG_STATUS, v);
        n[k]++;
      end while (v[3:0] !== ST_RUN && n[k] < 800);
      go(1'b0);
      wait_st(ST_IDLE, 10);
    end
    chk1(n[1] > n[0] + 40, 1'b1);
  endtask : t_rate

  task automatic t_rev;
    logic [DW-1:0] v;
    int i;
    reg_wr(REG_CTRL, 16'h0000);
    reg_wr(REG_STOP_DUR, 16'h0000);
    dir <= rev;
    go(1'b1);
    wait_f(16'h03e8, 400);
    @(posedge clk) dir <= ~dir;
    #1;
    for (i = 0; i < 600 && rev !== dir; i++) @(posedge clk) #1;
    chk1(rev, dir);
    reg_rd(REG_STATUS, v);
    chk({12'h000, v[3:0]}, {12'h000, ST_RUN});
    chk1(freq < 16'h00c8, 1'b1);
    brake_seen = 1'b0;
    go(1'b0);
    wait_st(ST_IDLE, 200);
    chk1(brake_seen, 1'b0);
  endtask : t_rev

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    for (int k = 1; k < 14; k++) reg_wr(k[AW-1:0], cfg_v[k]);
    t_standby();
    t_direct();
    t_sbrk();
    t_preex();
    t_track();
    t_rate();
    t_rev();
    results();
  end
endmodule : tb
`default_nettype wire

// *** common/dss_pkg.sv ***
// constants, register map and state codes for the drive start/stop sequencer
// Behaviour
// - direct start, zero brake time: run at once
// - direct start: brake for set time, then run
// - pre-excited start magnetises for set time; zero skips
// - pre-excitation only for asynchronous motors
// - tracking restart searches speed, starts at tracked frequency
// - hold startup frequency for hold time before accelerating
// - target below startup frequency: stay in standby
// - direction reversal skips the startup hold
// - startup braking only in direct start; percent current
// - search start: last stop, zero or maximum frequency
// - higher search rate searches faster
// - ramp stop decelerates, output off at zero
// - coast stop cuts output immediately
// - below onset frequency while decelerating, begin stop braking
// - remove output for wait time, then brake
// - stop braking drives the set percent current
// - brake for set duration; zero cancels braking
package dss_pkg;
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int FW = 16;
  localparam int PCTW = 7;
  localparam int REG_CNT = 14;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_START_FREQ = 4'h1;
  localparam logic [AW-1:0] REG_HOLD_TIME = 4'h2;
  localparam logic [AW-1:0] REG_START_CUR = 4'h3;
  localparam logic [AW-1:0] REG_START_TIME = 4'h4;
  localparam logic [AW-1:0] REG_SEARCH_RATE = 4'h5;
  localparam logic [AW-1:0] REG_ONSET_FREQ = 4'h6;
  localparam logic [AW-1:0] REG_WAIT_TIME = 4'h7;
  localparam logic [AW-1:0] REG_STOP_CUR = 4'h8;
  localparam logic [AW-1:0] REG_STOP_DUR = 4'h9;
  localparam logic [AW-1:0] REG_TARGET_FREQ = 4'ha;
  localparam logic [AW-1:0] REG_ACCEL_STEP = 4'hb;
  localparam logic [AW-1:0] REG_DECEL_STEP = 4'hc;
  localparam logic [AW-1:0] REG_MAX_FREQ = 4'hd;
  localparam logic [AW-1:0] REG_STATUS = 4'he;
  localparam logic [AW-1:0] REG_FREQ = 4'hf;
  // control register fields
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 2;
  localparam int CTL_SEARCH = 3;
  localparam int CTL_ASYNC = 5;
  localparam logic [1:0] START_DIRECT = 2'h0;
  localparam logic [1:0] START_PREEXC = 2'h1;
  localparam logic [1:0] START_TRACK = 2'h2;
  localparam logic [1:0] SEARCH_LAST = 2'h0;
  localparam logic [1:0] SEARCH_ZERO = 2'h1;
  localparam logic [1:0] SEARCH_MAX = 2'h2;
  localparam logic STOP_COAST = 1'b1;
  // status register fields
  localparam int STS_STATE = 0;
  localparam int STS_OUT_EN = 4;
  localparam int STS_BRAKE = 5;
  localparam int STS_PREEXC = 6;
  localparam int STS_REVERSE = 7;
  // limits: frequency in 0.01 Hz, time in 0.1 s, current in percent
  localparam logic [DW-1:0] STARTUP_FREQ_MAX = 16'h03e8;
  localparam logic [DW-1:0] TIME_MAX = 16'h03e8;
  localparam logic [DW-1:0] PCT_MAX = 16'h0064;
  localparam logic [DW-1:0] SEARCH_RATE_MIN = 16'h0001;
  localparam logic [DW-1:0] MAX_FREQ_RST = 16'h1388;
  localparam logic [DW-1:0] MAX_FREQ_LIMIT = 16'h7530;
  localparam logic [DW-1:0] FULL_SCALE = 16'hffff;
  localparam int TENTH_S_NS = 100000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYCLES_DEF = TENTH_S_NS / CLK_PERIOD_NS;
  localparam int SYNC_RUN = 0;
  localparam int SYNC_DIR = 1;
  localparam int SYNC_MATCH = 2;
  localparam int SYNC_MREV = 3;
  localparam int SYNC_W = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SBRK = 4'h1,
    ST_HOLD = 4'h3,
    ST_RUN = 4'h2,
    ST_DECEL = 4'h6,
    ST_SWAIT = 4'h7,
    ST_STBRK = 4'h5,
    ST_PREX = 4'h9,
    ST_SEARCH = 4'hb
  } dss_state_t;

  function automatic logic [DW-1:0] dss_reg_limit(input logic [AW-1:0] idx,
                                                   input logic [DW-1:0] v);
    logic [DW-1:0] lim;
    lim = FULL_SCALE;
    unique case (idx)
      REG_START_FREQ: lim = STARTUP_FREQ_MAX;
      REG_HOLD_TIME, REG_START_TIME, REG_WAIT_TIME, REG_STOP_DUR: lim = TIME_MAX;
      REG_START_CUR, REG_STOP_CUR, REG_SEARCH_RATE: lim = PCT_MAX;
      REG_MAX_FREQ: lim = MAX_FREQ_LIMIT;
      default: lim = FULL_SCALE;
    endcase
    return (v > lim) ? lim : v;
  endfunction : dss_reg_limit
endpackage : dss_pkg

// *** common/dss_ramp_if.sv ***
// frequency ramp control between sequencer and ramp generator
`timescale 1ns/1ps
`default_nettype none
interface dss_ramp_if;
  import dss_pkg::*;
  logic tick;
  logic load;
  logic [FW-1:0] load_val;
  logic [FW-1:0] target;
  logic [FW-1:0] step;
  logic [FW-1:0] freq;
  logic at_target;
  modport ctrl(output tick, load, load_val, target, step, input freq, at_target);
  modport ramp(input tick, load, load_val, target, step, output freq, at_target);
endinterface : dss_ramp_if
`default_nettype wire

// *** rtl/dss_ramp.sv ***
// output frequency ramp: moves toward target by step on each tick
`timescale 1ns/1ps
`default_nettype none
module dss_ramp import dss_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  dss_ramp_if.ramp r
);
  logic [FW-1:0] freq_q;
  logic [FW-1:0] freq_d;

  always_comb begin
    freq_d = freq_q;
    if (r.load) begin
      freq_d = r.load_val;
    end else if (r.tick) begin
      if (freq_q < r.target) begin
        freq_d = (r.target - freq_q > r.step) ? freq_q + r.step : r.target;
      end else if (freq_q > r.target) begin
        freq_d = (freq_q - r.target > r.step) ? freq_q - r.step : r.target;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_q <= '0;
    end else begin
      freq_q <= freq_d;
    end
  end

  assign r.freq = freq_q;
  assign r.at_target = (freq_q == r.target);
endmodule : dss_ramp
`default_nettype wire

// *** rtl/dss_sequencer.sv ***
// drive start/stop sequencer top: registers, state machine, power stage outputs
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer import dss_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RUN_CMD_I,
  input wire logic DIR_REV_I,
  input wire logic SPEED_MATCH_I,
  input wire logic MOTOR_REV_I,
  output logic [DW-1:0] RDATA_O,
  output logic [FW-1:0] FREQ_O,
  output logic OUTPUT_EN_O,
  output logic DC_BRAKE_O,
  output logic PREEXCITE_O,
  output logic [PCTW-1:0] BRAKE_CURRENT_O,
  output logic REVERSE_O
);
  dss_ramp_if rif();
  logic tick;
  logic [DW-1:0] cfg_q [REG_CNT];
  logic [DW-1:0] cfg_d [REG_CNT];
  logic [DW-1:0] rdata_d;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  dss_state_t state_q;
  dss_state_t state_d;
  logic [DW-1:0] timer_q;
  logic [DW-1:0] timer_d;
  logic rev_q;
  logic rev_d;
  logic skip_hold_q;
  logic skip_hold_d;
  logic [FW-1:0] last_freq_q;
  logic [FW-1:0] last_freq_d;
  logic en_d;
  logic brake_d;
  logic prex_d;
  logic [PCTW-1:0] cur_d;
  logic load;
  logic [FW-1:0] load_val;
  logic [FW-1:0] target;
  logic [FW-1:0] step;

  dss_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .tick_o(tick)
  );

  dss_ramp u_ramp (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .r(rif.ramp)
  );

  assign rif.tick = tick;
  assign rif.load = load;
  assign rif.load_val = load_val;
  assign rif.target = target;
  assign rif.step = step;
  assign FREQ_O = rif.freq;

  // configuration fields
  logic [1:0] start_mode;
  logic stop_mode;
  logic [1:0] search_start;
  logic motor_async;
  logic run_req;
  logic dir_req;
  logic [FW-1:0] freq;
  logic [FW-1:0] search_rate;
  assign start_mode = cfg_q[REG_CTRL][CTL_START +: 2];
  assign stop_mode = cfg_q[REG_CTRL][CTL_STOP];
  assign search_start = cfg_q[REG_CTRL][CTL_SEARCH +: 2];
  assign motor_async = cfg_q[REG_CTRL][CTL_ASYNC];
  assign run_req = sync_q[SYNC_RUN];
  assign dir_req = sync_q[SYNC_DIR];
  assign freq = rif.freq;
  // a zero rate would stall the search, so it counts as the slowest rate
  assign search_rate = (cfg_q[REG_SEARCH_RATE] < SEARCH_RATE_MIN) ?
                       SEARCH_RATE_MIN : cfg_q[REG_SEARCH_RATE];

  function automatic logic elapsed(input logic [DW-1:0] t, input logic [DW-1:0] setting);
    return t >= setting;
  endfunction : elapsed

  // register file and read port
  always_comb begin
    cfg_d = cfg_q;
    if (WR_I && (ADDR_I < AW'(REG_CNT))) begin
      cfg_d[ADDR_I] = dss_reg_limit(ADDR_I, WDATA_I);
    end
    rdata_d = '0;
    if (RD_I) begin
      if (ADDR_I < AW'(REG_CNT)) begin
        rdata_d = cfg_q[ADDR_I];
      end else if (ADDR_I == REG_STATUS) begin
        rdata_d[STS_STATE +: 4] = state_q;
        rdata_d[STS_OUT_EN] = OUTPUT_EN_O;
        rdata_d[STS_BRAKE] = DC_BRAKE_O;
        rdata_d[STS_PREEXC] = PREEXCITE_O;
        rdata_d[STS_REVERSE] = REVERSE_O;
      end else begin
        rdata_d = freq;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < REG_CNT; i++) begin
        cfg_q[i] <= '0;
      end
      cfg_q[REG_MAX_FREQ] <= MAX_FREQ_RST;
      RDATA_O <= '0;
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      RDATA_O <= rdata_d;
      meta_q <= {MOTOR_REV_I, SPEED_MATCH_I, DIR_REV_I, RUN_CMD_I};
      sync_q <= meta_q;
    end
  end

  // sequencer state machine
  always_comb begin
    state_d = state_q;
    rev_d = rev_q;
    skip_hold_d = skip_hold_q;
    last_freq_d = last_freq_q;
    target = freq;
    step = '0;
    unique case (state_q)
      ST_IDLE: begin
        if (run_req && (cfg_q[REG_TARGET_FREQ] >= cfg_q[REG_START_FREQ])) begin
          skip_hold_d = (dir_req != rev_q);
          rev_d = dir_req;
          unique case (start_mode)
            START_PREEXC: begin
              state_d = (motor_async && (cfg_q[REG_START_TIME] != '0)) ?
                        ST_PREX : ST_HOLD;
            end
            START_TRACK: state_d = ST_SEARCH;
            default: begin
              state_d = (cfg_q[REG_START_TIME] != '0) ? ST_SBRK : ST_HOLD;
            end
          endcase
        end
      end
      ST_SBRK, ST_PREX: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (elapsed(timer_q, cfg_q[REG_START_TIME])) begin
          state_d = ST_HOLD;
        end
      end
      ST_SEARCH: begin
        target = (search_start == SEARCH_ZERO) ? cfg_q[REG_MAX_FREQ] : '0;
        step = search_rate;
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (sync_q[SYNC_MATCH] || rif.at_target) begin
          state_d = ST_RUN;
          rev_d = sync_q[SYNC_MATCH] ? sync_q[SYNC_MREV] : rev_q;
        end
      end
      ST_HOLD: begin
        target = cfg_q[REG_START_FREQ];
        if (!run_req) begin
          state_d = (stop_mode == STOP_COAST) ? ST_IDLE : ST_DECEL;
          last_freq_d = freq;
        end else if (skip_hold_q || elapsed(timer_q, cfg_q[REG_HOLD_TIME])) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // a reversal ramps through zero and carries on without a hold
        target = (dir_req != rev_q) ? '0 : cfg_q[REG_TARGET_FREQ];
        step = (freq < target) ? cfg_q[REG_ACCEL_STEP] : cfg_q[REG_DECEL_STEP];
        if ((dir_req != rev_q) && (freq == '0)) begin
          rev_d = dir_req;
        end
        if (!run_req) begin
          state_d = (stop_mode == STOP_COAST) ? ST_IDLE : ST_DECEL;
          last_freq_d = freq;
        end
      end
      ST_DECEL: begin
        target = '0;
        step = cfg_q[REG_DECEL_STEP];
        if (run_req) begin
          state_d = ST_RUN;
        end else if ((cfg_q[REG_STOP_DUR] != '0) && (freq < cfg_q[REG_ONSET_FREQ])) begin
          state_d = ST_SWAIT;
        end else if (freq == '0) begin
          state_d = ST_IDLE;
        end
      end
      ST_SWAIT: begin
        if (elapsed(timer_q, cfg_q[REG_WAIT_TIME])) begin
          state_d = ST_STBRK;
        end
      end
      ST_STBRK: begin
        if (elapsed(timer_q, cfg_q[REG_STOP_DUR])) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // ramp preload on state entry
    load = 1'b0;
    load_val = '0;
    if (state_d != state_q) begin
      unique case (state_d)
        ST_HOLD: begin
          load = 1'b1;
          load_val = cfg_q[REG_START_FREQ];
        end
        ST_SEARCH: begin
          load = 1'b1;
          unique case (search_start)
            SEARCH_LAST: load_val = last_freq_q;
            SEARCH_MAX: load_val = cfg_q[REG_MAX_FREQ];
            default: load_val = '0;
          endcase
        end
        ST_RUN, ST_DECEL: load = 1'b0;
        default: load = 1'b1;
      endcase
    end
    timer_d = (state_d != state_q) ? '0 :
              (tick && (timer_q != FULL_SCALE)) ? timer_q + 16'h1 : timer_q;
    // power stage drive follows the next state
    en_d = 1'b0;
    brake_d = 1'b0;
    prex_d = 1'b0;
    cur_d = '0;
    unique case (state_d)
      ST_HOLD, ST_RUN, ST_DECEL, ST_SEARCH: en_d = 1'b1;
      ST_SBRK: begin
        brake_d = 1'b1;
        cur_d = cfg_q[REG_START_CUR][PCTW-1:0];
      end
      ST_PREX: begin
        prex_d = 1'b1;
        cur_d = cfg_q[REG_START_CUR][PCTW-1:0];
      end
      ST_STBRK: begin
        brake_d = 1'b1;
        cur_d = cfg_q[REG_STOP_CUR][PCTW-1:0];
      end
      default: en_d = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      rev_q <= 1'b0;
      skip_hold_q <= 1'b0;
      last_freq_q <= '0;
      OUTPUT_EN_O <= 1'b0;
      DC_BRAKE_O <= 1'b0;
      PREEXCITE_O <= 1'b0;
      BRAKE_CURRENT_O <= '0;
      REVERSE_O <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      rev_q <= rev_d;
      skip_hold_q <= skip_hold_d;
      last_freq_q <= last_freq_d;
      OUTPUT_EN_O <= en_d;
      DC_BRAKE_O <= brake_d;
      PREEXCITE_O <= prex_d;
      BRAKE_CURRENT_O <= cur_d;
      REVERSE_O <= rev_d;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_start_req;
    state_q == ST_IDLE && run_req && cfg_q[REG_TARGET_FREQ] >= cfg_q[REG_START_FREQ];
  endsequence
  sequence s_direct_start;
    s_start_req ##0 start_mode == START_DIRECT;
  endsequence

  property p_direct_no_brake;
    s_direct_start ##0 cfg_q[REG_START_TIME] == '0 |=> state_q == ST_HOLD && !DC_BRAKE_O;
  endproperty
  a_direct_no_brake: assert property (p_direct_no_brake) else $error("direct start braked");
  property p_direct_brake;
    s_direct_start ##0 cfg_q[REG_START_TIME] != '0 |=> DC_BRAKE_O && !OUTPUT_EN_O;
  endproperty
  a_direct_brake: assert property (p_direct_brake) else $error("startup brake missing");
  property p_preexc_async;
    s_start_req ##0 start_mode == START_PREEXC && !motor_async |=> !PREEXCITE_O;
  endproperty
  a_preexc_async: assert property (p_preexc_async) else $error("pre-excited sync motor");
  property p_standby;
    state_q == ST_IDLE && cfg_q[REG_TARGET_FREQ] < cfg_q[REG_START_FREQ] |=> !OUTPUT_EN_O;
  endproperty
  a_standby: assert property (p_standby) else $error("started below startup freq");
  property p_hold_freq;
    state_q == ST_HOLD |-> FREQ_O == cfg_q[REG_START_FREQ];
  endproperty
  a_hold_freq: assert property (p_hold_freq) else $error("hold freq wrong");
  property p_coast;
    state_q == ST_RUN && !run_req && stop_mode == STOP_COAST |=> !OUTPUT_EN_O ##1 FREQ_O == '0;
  endproperty
  a_coast: assert property (p_coast) else $error("coast kept output");
  property p_onset;
    state_q == ST_DECEL && !run_req && cfg_q[REG_STOP_DUR] != '0 &&
      freq < cfg_q[REG_ONSET_FREQ] |=> state_q == ST_SWAIT;
  endproperty
  a_onset: assert property (p_onset) else $error("onset missed");
  property p_wait_quiet;
    state_q == ST_SWAIT |-> !OUTPUT_EN_O && !DC_BRAKE_O;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("output during wait");
  property p_stop_current;
    state_q == ST_STBRK |-> DC_BRAKE_O && BRAKE_CURRENT_O == cfg_q[REG_STOP_CUR][PCTW-1:0];
  endproperty
  a_stop_current: assert property (p_stop_current) else $error("stop brake current");
  property p_no_brake_zero;
    state_q == ST_DECEL && cfg_q[REG_STOP_DUR] == '0 |=> state_q != ST_SWAIT;
  endproperty
  a_no_brake_zero: assert property (p_no_brake_zero) else $error("zero duration braked");
endmodule : dss_sequencer
`default_nettype wire

// *** rtl/dss_tick.sv ***
// tenth-of-a-second tick generator
`timescale 1ns/1ps
`default_nettype none
module dss_tick import dss_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_d;

  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule : dss_tick
`default_nettype wire
